/* hdl/polygon_fragment_control.sv */
`timescale 1ns/10ps
`include "poly_frag_defs.svh"
// Summary of operation
// RULE_01: Keep a 32 by 32 one-bit mask, loaded row by row from host words.
// RULE_02: With masking on, pass a fragment only if mask bit at x mod 32, y mod 32 is one.
// RULE_03: With masking off, treat every mask bit as one.
// RULE_04: Mask applies the same whether area antialiasing is on or off.
// RULE_05: Host may read back the stored mask row by row in the same packing.
// RULE_06: Antialiased fills carry the rasterizer coverage value with the fragment.
// RULE_07: Antialiased fragments skip the centre-sample and edge-ownership qualifier.
// RULE_08: Hold separate front and back styles; a write targets front, back or both.
// RULE_09: Point style forwards only vertices flagged as starting a boundary edge.
// RULE_10: Line style forwards boundary edges; pattern counter resets at first edge only.
// RULE_11: Style is applied only to polygons already lit, clipped and culled.
// RULE_12: Area antialiasing only in fill style; point and line use their own. out_aa still follows the area enable in point and line style.
// RULE_13: Offset per polygon is slope times factor plus resolution times units.
// RULE_14: Slope is the larger absolute depth gradient, an allowed approximation.
// RULE_15: One slope value per polygon, taken from its first triangle.
// RULE_16: Resolution is a constant for fixed point or two to exponent minus mantissa bits.
// RULE_17: Add offset only when the enable for the polygon style is set.
// RULE_18: Clamp offset depth to the unit interval.
// RULE_19: Multisampled fragments pass with coverage bits of satisfying samples only.
// RULE_20: Multisampling still culls faces and still applies the mask.
// RULE_21: Polygon multisample handling only in fill style.
// RULE_22: Reset gives all-ones mask, all enables off, fill style, zero factors.
// RULE_23: Cull front or back faces per the discard selection when culling is on.
module polygon_fragment_control #(
	parameter int COV_W = 8,                         // Coverage / sample mask width.
	parameter int DEPTH_FRAC = 16                    // Fraction bits of depth (1.0 = 2**DEPTH_FRAC).
) (
	input  wire logic        clk_sys,              // System clock, 40 MHz.
	input  wire logic        rst_n,                // Synchronous reset, active low.
	input  wire logic [7:0]  avs_address,          // Byte address.
	input  wire logic        avs_read,             // Read request.
	input  wire logic        avs_write,            // Write request.
	input  wire logic [31:0] avs_writedata,        // Write data.
	input  wire logic [3:0]  avs_byteenable,       // Byte enables.
	output logic [31:0]      avs_readdata,         // Read data.
	output logic             avs_waitrequest,      // Stall.
	input  wire logic        poly_start,           // Pulse: new polygon, gradients valid.
	input  wire logic        poly_area_neg,        // Signed area is negative.
	input  wire logic [31:0] poly_dzdx,            // Depth x gradient, signed fixed.
	input  wire logic [31:0] poly_dzdy,            // Depth y gradient, signed fixed.
	input  wire logic        in_valid,             // Fragment valid.
	output logic             in_ready,             // Fragment accepted.
	input  wire logic [15:0] in_x,                 // Window x.
	input  wire logic [15:0] in_y,                 // Window y.
	input  wire logic [31:0] in_z,                 // Depth, unsigned fixed.
	input  wire logic [1:0]  in_kind,              // 0 vertex, 1 edge, 2 interior.
	input  wire logic        in_boundary,          // Vertex/edge boundary flag.
	input  wire logic        in_first_edge,        // First boundary edge of polygon.
	input  wire logic        in_center_ok,         // Centre sample passes ownership rule.
	input  wire logic [COV_W-1:0] in_cov,          // Coverage or sample bits.
	output logic             out_valid,            // Fragment out valid.
	input  wire logic        out_ready,            // Downstream ready.
	output logic [15:0]      out_x,                // Window x.
	output logic [15:0]      out_y,                // Window y.
	output logic [31:0]      out_z,                // Offset and clamped depth.
	output logic [COV_W-1:0] out_cov,              // Coverage or sample bits.
	output logic [1:0]       out_prim,             // 0 point, 1 line, 2 polygon fill.
	output logic             out_aa,               // Area antialias enable from ctrl, set in every style.
	output logic             out_ms,               // Multisample rules apply.
	output logic             out_pattern_reset     // Reset line pattern counter.
);
	// Software state.
	logic [31:0] ctrl;
	logic [1:0]  style_front;
	logic [1:0]  style_back;
	logic [31:0] factor;
	logic [31:0] units;
	logic [31:0] resolve;
	logic [4:0]  mask_row;
	logic [31:0] mask [32];
	poly_frag_pkg::bus_state_t bstate;
	// Per-polygon state.
	logic        face_back;
	logic [31:0] offset;

	// Bus decode; all accesses complete one cycle after being seen so the master always waits at least once.
	wire         bus_req     = avs_read | avs_write;
	wire         bus_take    = (bstate == poly_frag_pkg::BUS_ACK);
	wire         wr_go       = bus_take & avs_write;
	wire [31:0]  be_mask     = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [4:0]   row_sel     = mask_row;
	wire [31:0]  wr_merge_c  = (ctrl & ~be_mask) | (avs_writedata & be_mask);
	wire [31:0]  wr_merge_m  = (mask[row_sel] & ~be_mask) | (avs_writedata & be_mask);
	wire [1:0]   new_style   = avs_writedata[`STYLE_LO +: 2];
	wire [1:0]   new_face    = avs_writedata[`FACE_LO +: 2];
	wire         style_legal = (new_style != 2'h3) && (new_face != 2'h3);

	// Mask lookup on window coordinate modulo 32.
	function automatic logic mask_bit(input logic [31:0] row, input logic [4:0] col);
		mask_bit = row[col];
	endfunction

	wire [31:0]  rd_mux =
		(avs_address == `OFS_CTRL)      ? ctrl :
		(avs_address == `OFS_STYLE)     ? {28'h0, style_back, style_front} :
		(avs_address == `OFS_FACTOR)    ? factor :
		(avs_address == `OFS_UNITS)     ? units :
		(avs_address == `OFS_RESOLVE)   ? resolve :
		(avs_address == `OFS_MASK_ROW)  ? {27'h0, mask_row} :
		(avs_address == `OFS_MASK_DATA) ? mask[row_sel] :
		(avs_address == `OFS_STATUS)    ? {29'h0, out_valid, face_back, in_ready} :
		32'h0;

	// Bus handshake: waitrequest is high except in the completing cycle.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bstate <= poly_frag_pkg::BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			case (bstate)
				poly_frag_pkg::BUS_IDLE: begin
					if (bus_req) begin
						bstate <= poly_frag_pkg::BUS_ACK;
						avs_waitrequest <= 1'b0;
						avs_readdata <= rd_mux;
					end
				end
				poly_frag_pkg::BUS_ACK: begin
					bstate <= poly_frag_pkg::BUS_WAIT;
					avs_waitrequest <= 1'b1;
				end
				poly_frag_pkg::BUS_WAIT: bstate <= poly_frag_pkg::BUS_IDLE;
				default: bstate <= poly_frag_pkg::BUS_IDLE;
			endcase
		end
	end

	// Register writes. The mask row pointer auto-advances after each data access for burst load and readback.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl <= `CTRL_RESET; // RULE_22
			style_front <= poly_frag_pkg::STYLE_FILL; // RULE_22
			style_back <= poly_frag_pkg::STYLE_FILL;
			factor <= 32'h0;
			units <= 32'h0;
			resolve <= `RESOLVE_RESET;
			mask_row <= 5'h0;
			for (int i = 0; i < 32; i++) mask[i] <= `MASK_ROW_RESET; // RULE_22
		end else if (bus_take) begin
			if (wr_go && avs_address == `OFS_CTRL) ctrl <= wr_merge_c;
			if (wr_go && avs_address == `OFS_STYLE && style_legal) begin // RULE_08
				if (new_face != poly_frag_pkg::FACE_BACK) style_front <= new_style;
				if (new_face != poly_frag_pkg::FACE_FRONT) style_back <= new_style;
			end
			if (wr_go && avs_address == `OFS_FACTOR) factor <= avs_writedata;
			if (wr_go && avs_address == `OFS_UNITS) units <= avs_writedata;
			if (wr_go && avs_address == `OFS_RESOLVE) resolve <= avs_writedata; // RULE_16
			if (wr_go && avs_address == `OFS_MASK_ROW) mask_row <= avs_writedata[4:0];
			if (avs_address == `OFS_MASK_DATA) begin // RULE_01 RULE_05
				if (avs_write) mask[row_sel] <= wr_merge_m;
				mask_row <= mask_row + 5'h1;
			end
		end
	end

	// Offset arithmetic: slope is the larger absolute gradient; products keep DEPTH_FRAC fraction bits.
	wire [31:0]  abs_dx   = poly_dzdx[31] ? (~poly_dzdx + 32'h1) : poly_dzdx;
	wire [31:0]  abs_dy   = poly_dzdy[31] ? (~poly_dzdy + 32'h1) : poly_dzdy;
	wire [31:0]  slope    = (abs_dx > abs_dy) ? abs_dx : abs_dy; // RULE_14 RULE_15
	wire signed [63:0] prod_m = $signed({32'h0, slope}) * $signed(factor);
	wire signed [63:0] prod_r = $signed({32'h0, resolve}) * $signed(units);
	wire signed [63:0] ofs_sum = (prod_m >>> DEPTH_FRAC) + prod_r; // RULE_13
	wire         face_now = poly_area_neg ^ ctrl[`CTRL_FRONT_CW];

	// Per-polygon latch of the offset and facing.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			offset <= 32'h0;
			face_back <= 1'b0;
		end else if (poly_start) begin
			offset <= ofs_sum[31:0];
			face_back <= face_now;
		end
	end

	// Fragment qualification, all combinational on the input beat.
	wire [1:0]   cull_sel  = ctrl[`CTRL_CULL_LO +: 2];
	wire         culled    = ctrl[`CTRL_CULL_EN] &&
		(face_back ? (cull_sel != poly_frag_pkg::FACE_FRONT) : (cull_sel != poly_frag_pkg::FACE_BACK)); // RULE_23 RULE_20
	wire [1:0]   style_now = face_back ? style_back : style_front; // RULE_11
	wire         is_fill   = (style_now == poly_frag_pkg::STYLE_FILL);
	wire         kind_ok   =
		(style_now == poly_frag_pkg::STYLE_POINT) ? (in_kind == 2'h0 && in_boundary) : // RULE_09
		(style_now == poly_frag_pkg::STYLE_LINE)  ? (in_kind == 2'h1 && in_boundary) : // RULE_10
		(in_kind == 2'h2);
	wire         aa_fill   = ctrl[`CTRL_AA_EN] & is_fill; // RULE_12
	wire         ms_on     = ctrl[`CTRL_MS_EN];
	wire         sample_ok = aa_fill | in_center_ok | (ms_on & is_fill); // RULE_07
	wire         cov_ok    = !(ms_on && is_fill) || (in_cov != '0); // RULE_19
	wire         mask_ok   = !ctrl[`CTRL_MASK_EN] || mask_bit(mask[in_y[4:0]], in_x[4:0]); // RULE_02 RULE_03 RULE_04
	wire         pass      = !culled && kind_ok && sample_ok && cov_ok && mask_ok;
	wire         ofs_en    =
		(style_now == poly_frag_pkg::STYLE_POINT) ? ctrl[`CTRL_OFS_PT] :
		(style_now == poly_frag_pkg::STYLE_LINE)  ? ctrl[`CTRL_OFS_LN] : ctrl[`CTRL_OFS_FL];
	wire signed [33:0] z_sum = $signed({2'b00, in_z}) + (ofs_en ? $signed({{2{offset[31]}}, offset}) : 34'sh0); // RULE_17
	wire [31:0]  z_clamp   = z_sum[33] ? 32'h0 : (z_sum > $signed({2'b00, `DEPTH_ONE})) ? `DEPTH_ONE : z_sum[31:0]; // RULE_18
	wire         out_free  = !out_valid || out_ready;

	// Input ready is a flip-flop, so it may only be high while the output slot is surely empty.
	// This halves the peak rate, but a passing fragment can never be taken and then lost to a stall.
	wire         take_in   = in_valid && in_ready;
	wire         load_out  = take_in && pass && out_free;
	wire         next_out_valid = load_out || (out_valid && !out_ready);

	// Output register stage; rejected fragments are consumed silently.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			in_ready <= 1'b0;
			out_x <= 16'h0;
			out_y <= 16'h0;
			out_z <= 32'h0;
			out_cov <= '0;
			out_prim <= 2'h2;
			out_aa <= 1'b0;
			out_ms <= 1'b0;
			out_pattern_reset <= 1'b0;
		end else begin
			in_ready <= !next_out_valid;
			if (take_in && pass && out_free) begin
				out_valid <= 1'b1;
				out_x <= in_x;
				out_y <= in_y;
				out_z <= z_clamp;
				out_cov <= (aa_fill || (ms_on && is_fill)) ? in_cov : {COV_W{1'b1}}; // RULE_06 RULE_19
				out_prim <= style_now; // RULE_21
				out_aa <= ctrl[`CTRL_AA_EN];
				out_ms <= ms_on;
				out_pattern_reset <= (style_now == poly_frag_pkg::STYLE_LINE) && in_first_edge; // RULE_10
			end else if (out_ready) begin
				out_valid <= 1'b0;
				out_pattern_reset <= 1'b0; // RULE_10
			end
		end
	end

	// Checks.
	property p_mask_block;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && ctrl[`CTRL_MASK_EN] && !mask[in_y[4:0]][in_x[4:0]]) |=> !(out_valid && !$past(out_valid));
	endproperty
	a_mask_block: assert property (p_mask_block) else $error("masked fragment forwarded"); // RULE_02
	property p_clamp;
		@(posedge clk_sys) disable iff (!rst_n)
		out_valid |-> (out_z <= `DEPTH_ONE);
	endproperty
	a_clamp: assert property (p_clamp) else $error("depth above one"); // RULE_18
	property p_cull;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && culled && !out_valid) |=> !out_valid;
	endproperty
	a_cull: assert property (p_cull) else $error("culled fragment forwarded"); // RULE_23
	// The answer is one low cycle of waitrequest, then high again.
	sequence s_ack_pulse;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	property p_wait_one;
		@(posedge clk_sys) disable iff (!rst_n)
		(bus_req && bstate == poly_frag_pkg::BUS_IDLE) |=> s_ack_pulse;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong"); // RULE_05
	property p_point_style;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && pass && out_free && style_now == poly_frag_pkg::STYLE_POINT) |=> (out_prim == 2'h0);
	endproperty
	a_point_style: assert property (p_point_style) else $error("point style lost"); // RULE_09
	property p_ms_cov;
		@(posedge clk_sys) disable iff (!rst_n)
		(out_valid && out_ms && out_prim == 2'h2) |-> (out_cov != '0);
	endproperty
	a_ms_cov: assert property (p_ms_cov) else $error("empty coverage forwarded"); // RULE_19
	property p_pat_reset;
		@(posedge clk_sys) disable iff (!rst_n)
		out_pattern_reset |-> (out_valid && out_prim == 2'h1);
	endproperty
	a_pat_reset: assert property (p_pat_reset) else $error("pattern reset outside line"); // RULE_10
	property p_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(out_valid && !out_ready) |=> (out_valid && $stable(out_z) && $stable(out_x));
	endproperty
	a_hold: assert property (p_hold) else $error("output changed under stall"); // RULE_13

	// A passing fragment that is taken appears at the output next cycle.
	property p_pass_fwd;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && pass) |=> out_valid;
	endproperty
	a_pass_fwd: assert property (p_pass_fwd) else $error("passing fragment lost"); // RULE_02

	// With masking off, the mask never holds a fragment back.
	property p_mask_off;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && !ctrl[`CTRL_MASK_EN] && !culled && kind_ok && sample_ok && cov_ok) |=> out_valid;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("fragment dropped with mask off"); // RULE_03

	// A style write aimed at front faces leaves the back style alone.
	property p_style_face;
		@(posedge clk_sys) disable iff (!rst_n)
		(wr_go && avs_address == `OFS_STYLE && new_face == poly_frag_pkg::FACE_FRONT) |=> $stable(style_back);
	endproperty
	a_style_face: assert property (p_style_face) else $error("back style changed"); // RULE_08

	// Reset state is checked with reset itself as the trigger.
	property p_reset_vals;
		@(posedge clk_sys)
		!rst_n |=> (ctrl == `CTRL_RESET && factor == 32'h0 && units == 32'h0 &&
			style_back == poly_frag_pkg::STYLE_FILL && mask[31] == `MASK_ROW_RESET);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset state wrong"); // RULE_22

	// Point and line fragments carry full coverage, never area coverage.
	property p_nonfill_cov;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_out && !is_fill) |=> (out_cov == {COV_W{1'b1}});
	endproperty
	a_nonfill_cov: assert property (p_nonfill_cov) else $error("area coverage outside fill"); // RULE_12

	// Without the offset enable a depth no greater than one passes unchanged.
	property p_no_offset;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_out && !ofs_en && in_z <= `DEPTH_ONE) |=> (out_z == $past(in_z));
	endproperty
	a_no_offset: assert property (p_no_offset) else $error("offset added while disabled"); // RULE_17

	// Multisampled fills keep their sample bits.
	property p_ms_fill_cov;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_out && ms_on && is_fill) |=> (out_cov == $past(in_cov));
	endproperty
	a_ms_fill_cov: assert property (p_ms_fill_cov) else $error("sample bits lost"); // RULE_21

	// Each mask data access moves the row pointer on by one.
	property p_row_step;
		@(posedge clk_sys) disable iff (!rst_n)
		(bus_take && avs_address == `OFS_MASK_DATA) |=> (mask_row == $past(mask_row) + 5'h1);
	endproperty
	a_row_step: assert property (p_row_step) else $error("mask row pointer wrong"); // RULE_01

	// The offset changes only at a polygon start.
	property p_offset_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		!poly_start |=> $stable(offset);
	endproperty
	a_offset_hold: assert property (p_offset_hold) else $error("offset changed inside polygon"); // RULE_13

	// A negative offset depth is clamped to zero.
	property p_clamp_low;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_out && z_sum[33]) |=> (out_z == 32'h0);
	endproperty
	a_clamp_low: assert property (p_clamp_low) else $error("depth below zero"); // RULE_18

	// Back faces are dropped while back culling is on.
	property p_cull_back;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && face_back && ctrl[`CTRL_CULL_EN] && cull_sel == 2'h1) |=> !out_valid;
	endproperty
	a_cull_back: assert property (p_cull_back) else $error("back face forwarded"); // RULE_23

	// Antialiased fills carry the coverage from the rasterizer.
	property p_cov_kept;
		@(posedge clk_sys) disable iff (!rst_n)
		(load_out && aa_fill) |=> (out_cov == $past(in_cov));
	endproperty
	a_cov_kept: assert property (p_cov_kept) else $error("coverage lost"); // RULE_06

	// A multisampled fill with no covered sample is dropped.
	property p_ms_reject;
		@(posedge clk_sys) disable iff (!rst_n)
		(take_in && ms_on && is_fill && in_cov == '0) |=> !out_valid;
	endproperty
	a_ms_reject: assert property (p_ms_reject) else $error("empty sample set forwarded"); // RULE_19
endmodule

/* shared/poly_frag_defs.svh */
`ifndef POLY_FRAG_DEFS_SVH
`define POLY_FRAG_DEFS_SVH
// Register word offsets (byte addresses on the Avalon bus).
`define OFS_CTRL        8'h00
`define OFS_STYLE       8'h04
`define OFS_FACTOR      8'h08
`define OFS_UNITS       8'h0c
`define OFS_RESOLVE     8'h10
`define OFS_MASK_ROW    8'h14
`define OFS_MASK_DATA   8'h18
`define OFS_STATUS      8'h1c
// Control register field positions.
`define CTRL_MASK_EN    0
`define CTRL_AA_EN      1
`define CTRL_CULL_EN    2
`define CTRL_MS_EN      3
`define CTRL_OFS_PT     4
`define CTRL_OFS_LN     5
`define CTRL_OFS_FL     6
`define CTRL_CULL_LO    8
`define CTRL_FRONT_CW   10
// Style register fields: low two bits style, next two bits face target.
`define STYLE_LO        0
`define FACE_LO         2
// Reset values.
`define CTRL_RESET      32'h0000_0100
`define MASK_ROW_RESET  32'hffff_ffff
`define RESOLVE_RESET   32'h0000_0001
`define DEPTH_ONE       32'h0001_0000
`endif

/* shared/poly_frag_pkg.sv */
package poly_frag_pkg;
	typedef enum logic [1:0] {
		STYLE_POINT = 2'h0,
		STYLE_LINE  = 2'h1,
		STYLE_FILL  = 2'h2
	} raster_style_t;
	typedef enum logic [1:0] {
		FACE_FRONT = 2'h0,
		FACE_BACK  = 2'h1,
		FACE_BOTH  = 2'h2
	} face_sel_t;
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACK  = 3'b010,
		BUS_WAIT = 3'b100
	} bus_state_t;
endpackage

/* testbench/frag_sink.sv */
`timescale 1ns/10ps
// Downstream fragment sink that records the last fragment it took.
module frag_sink (
	input  wire logic        clk_sys,   // System clock.
	input  wire logic        rst_n,     // Reset, active low.
	input  wire logic        slow,      // Stall on alternate cycles.
	input  wire logic        out_valid, // Fragment valid.
	output logic             out_ready, // Sink ready.
	input  wire logic [31:0] out_z,     // Depth.
	input  wire logic [7:0]  out_cov,   // Coverage bits.
	input  wire logic [1:0]  out_prim,  // Primitive kind.
	input  wire logic [2:0]  out_flags, // Antialias, multisample, pattern reset.
	input  wire logic [31:0] out_xy,    // Window x and y.
	output logic [7:0]       rx_n,      // Fragments taken.
	output logic [31:0]      rx_z,      // Last depth.
	output logic [7:0]       rx_cov,    // Last coverage.
	output logic [1:0]       rx_prim,   // Last kind.
	output logic [31:0]      rx_xy,     // Last window x and y.
	output logic [2:0]       rx_flags   // Last flags.
);
	logic toggle;
	// Ready drops every other cycle when slow, so a held output must survive a stall.
	assign out_ready = !slow || toggle;
	// A fragment counts only at the edge where valid meets ready.
	always_ff @(posedge clk_sys) begin
		toggle <= rst_n ? !toggle : 1'b0;
		if (!rst_n) begin
			rx_n <= 8'h00;
		end else if (out_valid && out_ready) begin
			rx_n <= rx_n + 8'h01;
			rx_z <= out_z;
			rx_cov <= out_cov;
			rx_prim <= out_prim;
			rx_flags <= out_flags;
			rx_xy <= out_xy;
		end
	end
endmodule

/* testbench/tb.sv */
`timescale 1ns/10ps
`include "poly_frag_defs.svh"
module tb;
	logic clk_sys = 1'b0, rst_n = 1'b0, slow = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00, in_cov = 8'h00, out_cov, rx_n, rx_cov;
	logic [31:0] avs_writedata = 32'h0, poly_dzdx = 32'h0, poly_dzdy = 32'h0, in_z = 32'h0;
	logic [31:0] avs_readdata, out_z, rx_z, rx_xy;
	logic [3:0] avs_byteenable = 4'hf;
	logic avs_waitrequest, in_ready, out_valid, out_ready, out_aa, out_ms, out_pattern_reset;
	logic poly_start = 1'b0, poly_area_neg = 1'b0, in_valid = 1'b0;
	logic in_boundary = 1'b0, in_first_edge = 1'b0, in_center_ok = 1'b1;
	logic [15:0] in_x = 16'h0, in_y = 16'h0, out_x, out_y;
	logic [1:0] in_kind = 2'h2, out_prim, rx_prim;
	logic [2:0] rx_flags;
	int errors = 0, n_tests = 0;
	int rows [3] = '{0, 5, 31};
	// Free-running 40 MHz clock.
	always #12.5 clk_sys = ~clk_sys;
	polygon_fragment_control i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .poly_start,
		.poly_area_neg, .poly_dzdx, .poly_dzdy, .in_valid, .in_ready, .in_x, .in_y, .in_z,
		.in_kind, .in_boundary, .in_first_edge, .in_center_ok, .in_cov, .out_valid, .out_ready,
		.out_x, .out_y, .out_z, .out_cov, .out_prim, .out_aa, .out_ms, .out_pattern_reset);
	frag_sink i_sink (.clk_sys, .rst_n, .slow, .out_valid, .out_ready, .out_z, .out_cov, .out_prim,
		.out_flags({out_aa, out_ms, out_pattern_reset}), .out_xy({out_x, out_y}), .rx_n, .rx_z, .rx_cov,
		.rx_prim, .rx_flags, .rx_xy);
	// Compare and count; an unknown never matches.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One Avalon access, held until waitrequest is seen low, then two idle cycles.
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= we;
		avs_read <= !we;
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (k == 20) begin
			errors++;
			give_verdict();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~wd;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, a, wd, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(nm, d, exp);
	endtask
	task automatic poly(input logic neg, input logic [31:0] gx, input logic [31:0] gy);
		poly_start <= 1'b1;
		poly_area_neg <= neg;
		poly_dzdx <= gx;
		poly_dzdy <= gy;
		@(posedge clk_sys);
		poly_start <= 1'b0;
		@(posedge clk_sys);
	endtask
	// One fragment; odd x marks the first edge, coverage follows x so it is traceable.
	task automatic frag(input logic [15:0] x, y, input logic [31:0] z, input logic [1:0] kd,
		input logic bnd, pass);
		int k;
		logic [7:0] n0;
		n0 = rx_n;
		in_valid <= 1'b1;
		{in_x, in_y, in_z, in_kind, in_boundary} <= {x, y, z, kd, bnd};
		{in_first_edge, in_cov} <= {x[0], x[7:0]};
		for (k = 0; k < 20; k++) begin
			@(posedge clk_sys);
			if (in_ready === 1'b1) break;
		end
		if (k == 20) begin
			errors++;
			give_verdict();
		end
		in_valid <= 1'b0;
		{in_x, in_z} <= {~x, ~z};
		repeat (8) @(posedge clk_sys);
		chk("taken", {24'h0, rx_n - n0}, {31'h0, pass});
		if (pass) chk("xy", rx_xy, {x, y});
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rdc("ctrl", `OFS_CTRL, 32'h0000_0100);
		rdc("style", `OFS_STYLE, 32'h0000_000a);
		rdc("factor", `OFS_FACTOR, 32'h0);
		rdc("units", `OFS_UNITS, 32'h0);
		rdc("resolve", `OFS_RESOLVE, 32'h1);
		rdc("mask", `OFS_MASK_DATA, 32'hffff_ffff);
		rdc("unmapped", 8'hfc, 32'h0);
		wr(`OFS_MASK_ROW, 32'h0);
		for (int r = 0; r < 32; r++) wr(`OFS_MASK_DATA, 32'h1 << r);
		wr(`OFS_MASK_ROW, 32'h0);
		for (int r = 0; r < 32; r++) rdc("mask row", `OFS_MASK_DATA, 32'h1 << r);
		poly(1'b0, 32'h0, 32'h0);
		wr(`OFS_CTRL, 32'h0000_0100);
		frag(16'd33, 16'd64, 32'h1000, 2'h2, 1'b0, 1'b1);
		// Same mask result with area antialiasing off and on.
		for (int m = 0; m < 2; m++) begin
			wr(`OFS_CTRL, 32'h0000_0101 | (m << 1));
			foreach (rows[i]) begin
				frag(16'd32 + rows[i], 16'd64 + rows[i], 32'h1000, 2'h2, 1'b0, 1'b1);
				chk("aa", rx_flags[2], m);
				chk("cov", rx_cov, m ? 8'd32 + rows[i] : 8'hff);
				frag(16'd33 + rows[i], 16'd64 + rows[i], 32'h1000, 2'h2, 1'b0, 1'b0);
			end
		end
		slow <= 1'b1;
		wr(`OFS_CTRL, 32'h0000_0140);
		wr(`OFS_FACTOR, 32'h0002_0000);
		wr(`OFS_UNITS, 32'h3);
		poly(1'b0, 32'h0000_0100, 32'hffff_fc00);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		chk("z offset", rx_z, 32'h1803);
		frag(16'd0, 16'd0, 32'h000f_fff0, 2'h2, 1'b0, 1'b1);
		chk("z high clamp", rx_z, `DEPTH_ONE);
		wr(`OFS_FACTOR, 32'h0);
		wr(`OFS_UNITS, 32'hffff_0000);
		poly(1'b0, 32'h0, 32'h0);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		chk("z low clamp", rx_z, 32'h0);
		wr(`OFS_CTRL, 32'h0000_0130);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		chk("z no fill offset", rx_z, 32'h1000);
		wr(`OFS_CTRL, 32'h0000_0104);
		poly(1'b1, 32'h0, 32'h0);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b0);
		rdc("status", `OFS_STATUS, 32'h3);
		poly(1'b0, 32'h0, 32'h0);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		wr(`OFS_CTRL, 32'h0000_0204);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b0);
		// Front faces in point style, back faces stay fill; an illegal style is ignored.
		wr(`OFS_STYLE, 32'h0);
		wr(`OFS_STYLE, 32'hf);
		rdc("style pt", `OFS_STYLE, 32'h8);
		wr(`OFS_CTRL, 32'h0000_0110);
		wr(`OFS_UNITS, 32'h3);
		poly(1'b0, 32'h0, 32'h0);
		frag(16'd4, 16'd0, 32'h1000, 2'h0, 1'b1, 1'b1);
		chk("pt prim", rx_prim, 2'h0);
		chk("pt z", rx_z, 32'h1003);
		frag(16'd4, 16'd0, 32'h1000, 2'h0, 1'b0, 1'b0);
		poly(1'b1, 32'h0, 32'h0);
		frag(16'd4, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		chk("back prim", rx_prim, 2'h2);
		wr(`OFS_STYLE, 32'h9);
		rdc("style ln", `OFS_STYLE, 32'h5);
		poly(1'b0, 32'h0, 32'h0);
		frag(16'd1, 16'd0, 32'h1000, 2'h1, 1'b1, 1'b1);
		chk("ln first", {rx_prim, rx_flags[0]}, 3'b011);
		frag(16'd2, 16'd0, 32'h1000, 2'h1, 1'b1, 1'b1);
		chk("ln next", {rx_prim, rx_flags[0]}, 3'b010);
		chk("ln z", rx_z, 32'h1000);
		wr(`OFS_STYLE, 32'ha);
		wr(`OFS_CTRL, 32'h0000_0108);
		frag(16'd5, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b1);
		chk("ms", {rx_flags[1], rx_cov}, 9'h105);
		frag(16'd0, 16'd0, 32'h1000, 2'h2, 1'b0, 1'b0);
		wr(`OFS_CTRL, 32'h0000_010d);
		frag(16'd32, 16'd64, 32'h1000, 2'h2, 1'b0, 1'b1);
		frag(16'd33, 16'd64, 32'h1000, 2'h2, 1'b0, 1'b0);
		poly(1'b1, 32'h0, 32'h0);
		frag(16'd32, 16'd64, 32'h1000, 2'h2, 1'b0, 1'b0);
		give_verdict();
	end
endmodule
